// ===== design/mivl_latch_bank.sv
// module: media-id valid reporting, tape drive register and function control register
//
// What this block does
// R01: sample both straps in reset, drive bit 5
// R02: drive 0 strap low: bit 5 reads 0
// R03: drive 0 strap high: bit 5 reads 1
// R04: same reporting for drive 1 when selected
// R05: drive 0 strap loads control bit 0
// R06: control bit 0 set: straps meaningless
// R07: samples stay fixed until next reset
//
// Our own choice: the address-and-strobe port.
`timescale 1ns/100ps

module mivl_latch_bank
    import mivl_pkg::*;
(
    input  wire logic              mclk_i,                           // controller clock, 100 MHz
    input  wire logic              srst_i,                           // synchronous reset, high
    input  wire logic              media_valid_strap_drive0_n_i,     // drive 0 strap, low = id valid
    input  wire logic              media_valid_strap_drive1_n_i,     // drive 1 strap, low = id valid
    input  wire logic              drive_sel_i,                      // selected drive, 0 or 1
    input  wire logic [1:0]        media_id_i,                       // media id of selected drive
    input  wire logic [ADDR_W-1:0] addr_i,                           // register address
    input  wire logic [DATA_W-1:0] wdata_i,                          // register write data
    input  wire logic              wr_i,                             // write strobe
    input  wire logic              rd_i,                             // read strobe
    output logic      [DATA_W-1:0] rdata_o,                          // read data, cycle after rd_i
    output logic                   data_rate_select_o,               // function control bit 0
    output logic      [1:0]        tape_sel_o                        // tape drive select field
);

    // ****************************************************************
    // decode helper
    // ****************************************************************

    // address match, used for both the write and the read side
    // full compare on all address bits, so no alias of a register answers
    function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] off);
        hit = (a == off);
    endfunction : hit

    // ****************************************************************
    // bus bundle
    // ****************************************************************
    // the carrier keeps one request together for every decode below
    mivl_bus_req_t req;                                              // gathered host request

    always_comb begin
        // gather the loose port signals into one carrier
        // no logic here, only renaming
        req.addr  = addr_i;
        req.wdata = wdata_i;
        req.wr    = wr_i;
        req.rd    = rd_i;
    end

    // ****************************************************************
    // strap sampling
    // ****************************************************************
    logic [NUM_DRIVES-1:0] strap_pins;                               // raw straps, drive order
    logic [NUM_DRIVES-1:0] strap_held;                               // straps held since reset

    assign strap_pins = {media_valid_strap_drive1_n_i, media_valid_strap_drive0_n_i};

    // straps are board resistors, so no synchroniser is needed; they
    // are treated as synchronous and only looked at while reset is high
    // limitation: a strap still settling at the last reset edge is taken
    // as it stands then; the board must hold it steady during reset
    mivl_strap_latch #(
        .N       (NUM_DRIVES)
    ) u_strap_latch (
        .mclk_i  (mclk_i),
        .srst_i  (srst_i),                                           // R01
        .strap_i (strap_pins),
        .strap_o (strap_held)                                        // R07
    );

    // ****************************************************************
    // control registers
    // ****************************************************************
    logic [DATA_W-1:0] func_ctrl;                                    // function_control_reg
    logic [DATA_W-1:0] next_func_ctrl;                               // its next value
    logic [1:0]        tape_sel;                                     // tape select field
    logic [1:0]        next_tape_sel;                                // its next value

    // reset wins over a write in the same cycle, so software cannot
    // overwrite the strap-loaded mode bit before the straps are taken
    // next values of the writable state
    always_comb begin
        next_func_ctrl = func_ctrl;
        next_tape_sel  = tape_sel;
        if (srst_i) begin
            // drive 0 strap picks media sense (0) or data-rate signalling (1)
            next_func_ctrl                    = FCR_RST_UPPER;
            next_func_ctrl[FCR_DATA_RATE_BIT] = media_valid_strap_drive0_n_i;  // R05
            next_tape_sel                     = TAPE_SEL_RST;
        end else if (req.wr && hit(req.addr, FUNC_CTRL_OFF)) begin
            // software may change the mode after reset
            next_func_ctrl = req.wdata;
        end else if (req.wr && hit(req.addr, TAPE_DRIVE_OFF)) begin
            // only the tape select bits are writable; the rest is status
            next_tape_sel = req.wdata[TDR_TAPE_SEL_LSB +: 2];
        end
    end

    // register the control state
    // both fields share one flop group and one reset
    always_ff @(posedge mclk_i) begin
        func_ctrl <= next_func_ctrl;
        tape_sel  <= next_tape_sel;
    end

    assign data_rate_select_o = func_ctrl[FCR_DATA_RATE_BIT];
    assign tape_sel_o         = tape_sel;

    // ****************************************************************
    // tape drive register view
    // ****************************************************************
    mivl_tdr_t tdr_view;                                             // live register contents
    logic      sel_strap;                                            // strap of selected drive

    always_comb begin
        // drive 1 follows exactly the same rule as drive 0
        // the view is combinational; the read path registers it, so a
        // select that changes after the strobe cannot reach the answer
        sel_strap = drive_sel_i ? strap_held[1] : strap_held[0];     // R04
        tdr_view.media_id = media_id_i;
        tdr_view.unused   = 3'h0;
        tdr_view.tape_sel = tape_sel;
        if (func_ctrl[FCR_DATA_RATE_BIT]) begin
            // in data-rate mode the straps carry no id meaning, so the
            // id is always reported as not valid
            tdr_view.id_invalid = ID_MEANINGLESS;                    // R06
        end else begin
            // low strap reads 0 (id valid), high strap reads 1 (not valid)
            tdr_view.id_invalid = sel_strap;                         // R02 R03
        end
    end

    // ****************************************************************
    // read path
    // ****************************************************************
    logic [DATA_W-1:0] rdata;                                        // registered read data
    logic [DATA_W-1:0] next_rdata;                                   // its next value

    // read data stand only in the cycle after the strobe, zero otherwise;
    // unmapped addresses answer zero so the host never waits
    // strobes during reset are dropped too, so a read that races reset
    // release sees zero rather than a half-loaded register
    always_comb begin
        next_rdata = RDATA_IDLE;
        if (!srst_i && req.rd) begin
            if (hit(req.addr, TAPE_DRIVE_OFF)) begin
                next_rdata = tdr_view;                               // R01
            end else if (hit(req.addr, FUNC_CTRL_OFF)) begin
                next_rdata = func_ctrl;
            end else begin
                next_rdata = RDATA_IDLE;
            end
        end
    end

    // register the answer
    // one flop stage, so the answer stands exactly one cycle
    always_ff @(posedge mclk_i) begin
        rdata <= next_rdata;
    end

    assign rdata_o = rdata;

    // ****************************************************************
    // assertions
    // ****************************************************************
    // every check runs on the controller clock; reset handling is per property
    default clocking cb @(posedge mclk_i); endclocking

    // a status read with the given drive selected, outside reset
    sequence tdr_read_s(logic drv);
        !srst_i && rd_i && hit(addr_i, TAPE_DRIVE_OFF) && (drive_sel_i == drv);
    endsequence

    // media sense mode, control bit 0 clear, to pair with a status read
    sequence sense_mode_s;
        !func_ctrl[FCR_DATA_RATE_BIT];
    endsequence

    strap_sample_a: assert property ( // R01
        srst_i |=> (strap_held == $past(strap_pins)))
        else $error("strap not sampled during reset");

    drv0_valid_a: assert property (disable iff (srst_i) // R02
        (tdr_read_s(1'b0) and sense_mode_s) ##0 !strap_held[0] |=> !rdata_o[TDR_ID_INVALID_BIT])
        else $error("drive 0 valid id not reported as 0");

    drv0_invalid_a: assert property (disable iff (srst_i) // R03
        (tdr_read_s(1'b0) and sense_mode_s) ##0 strap_held[0] |=> rdata_o[TDR_ID_INVALID_BIT])
        else $error("drive 0 invalid id not reported as 1");

    drv1_report_a: assert property (disable iff (srst_i) // R04
        (tdr_read_s(1'b1) and sense_mode_s) |=> (rdata_o[TDR_ID_INVALID_BIT] == $past(strap_held[1])))
        else $error("drive 1 bit 5 does not follow its strap");

    fcr_load_a: assert property ( // R05
        srst_i |=> (data_rate_select_o == $past(media_valid_strap_drive0_n_i)) && (func_ctrl[7:1] == 7'h00))
        else $error("control bit 0 not loaded from drive 0 strap");

    rate_mode_a: assert property (disable iff (srst_i) // R06
        (tdr_read_s(1'b0) or tdr_read_s(1'b1)) ##0 func_ctrl[FCR_DATA_RATE_BIT]
            |=> rdata_o[TDR_ID_INVALID_BIT])
        else $error("bit 5 not forced in data-rate mode");

    strap_hold_a: assert property (disable iff (srst_i) // R07
        !$past(srst_i) |-> $stable(strap_held))
        else $error("held strap changed outside reset");

    read_window_a: assert property (disable iff (srst_i) // R01
        !rd_i |=> (rdata_o == RDATA_IDLE))
        else $error("read data outside the answer cycle");

    // ****************************************************************
    // register port assertions
    // ****************************************************************
    // these watch the host side: two more drive 1 strap checks, then checks that trip if the
    // decode, a write, a reset or the read register loses a field or moves one unbidden

    // a write strobe to the given offset, outside reset
    sequence reg_write_s(logic [ADDR_W-1:0] off);
        !srst_i && wr_i && hit(addr_i, off);
    endsequence

    // a read strobe to the given offset, outside reset
    sequence reg_read_s(logic [ADDR_W-1:0] off);
        !srst_i && rd_i && hit(addr_i, off);
    endsequence

    // a read strobe that neither register claims
    sequence stray_read_s;
        !srst_i && rd_i && !hit(addr_i, TAPE_DRIVE_OFF) && !hit(addr_i, FUNC_CTRL_OFF);
    endsequence

    // drive 1 strap low reads as a valid id
    drv1_valid_a: assert property (disable iff (srst_i) // R04
        (tdr_read_s(1'b1) and sense_mode_s) ##0 !strap_held[1] |=> !rdata_o[TDR_ID_INVALID_BIT])
        else $error("drive 1 valid id not reported as 0");

    // drive 1 strap high reads as an invalid id
    drv1_invalid_a: assert property (disable iff (srst_i) // R04
        (tdr_read_s(1'b1) and sense_mode_s) ##0 strap_held[1] |=> rdata_o[TDR_ID_INVALID_BIT])
        else $error("drive 1 invalid id not reported as 1");

    // media id passes in both modes; it is taken with the strobe, so an
    // id that moves afterwards must not show
    media_id_a: assert property (disable iff (srst_i) // R01
        (tdr_read_s(1'b0) or tdr_read_s(1'b1)) |=> (rdata_o[TDR_MEDIA_ID_LSB +: 2] == $past(media_id_i)))
        else $error("media id field not taken with the read strobe");

    // the three bits below the valid flag, bits 4:2, read zero
    unused_zero_a: assert property (disable iff (srst_i) // R01
        (tdr_read_s(1'b0) or tdr_read_s(1'b1)) |=> (rdata_o[TDR_ID_INVALID_BIT-1 -: 3] == 3'h0))
        else $error("unused status bits not zero");

    // the tape select field reads back what was last written
    tsel_echo_a: assert property (disable iff (srst_i) // R01
        (tdr_read_s(1'b0) or tdr_read_s(1'b1)) |=> (rdata_o[TDR_TAPE_SEL_LSB +: 2] == $past(tape_sel_o)))
        else $error("tape select field not in status read");

    // a control write lands whole at its edge, mode bit included
    fcr_write_a: assert property (disable iff (srst_i) // R05
        reg_write_s(FUNC_CTRL_OFF) |=> (func_ctrl == $past(wdata_i)))
        else $error("control write did not land");

    // only the select bits of a status write are kept
    tsel_write_a: assert property (disable iff (srst_i) // R01
        reg_write_s(TAPE_DRIVE_OFF) |=> (tape_sel_o == $past(wdata_i[TDR_TAPE_SEL_LSB +: 2])))
        else $error("tape select write did not land");

    // the control register reads back as it stood at the strobe
    fcr_read_a: assert property (disable iff (srst_i) // R05
        reg_read_s(FUNC_CTRL_OFF) |=> (rdata_o == $past(func_ctrl)))
        else $error("control read returned wrong value");

    // an address no register claims answers zero, never stale data
    stray_read_a: assert property (disable iff (srst_i) // R01
        stray_read_s |=> (rdata_o == RDATA_IDLE))
        else $error("unmapped read did not return zero");

    // reset clears the answer and the tape select whatever the strobes do;
    // no disable here, since this is the reset behaviour itself
    reset_quiet_a: assert property ( // R01
        srst_i |=> (rdata_o == RDATA_IDLE) && (tape_sel_o == TAPE_SEL_RST))
        else $error("reset did not clear read data and tape select");

    // the mode bit moves only by a control write or a reset
    fcr_keep_a: assert property (disable iff (srst_i) // R06
        !(wr_i && hit(addr_i, FUNC_CTRL_OFF)) |=> $stable(func_ctrl))
        else $error("control register changed without a write");

    // the tape select moves only by a status write or a reset
    tsel_keep_a: assert property (disable iff (srst_i) // R01
        !(wr_i && hit(addr_i, TAPE_DRIVE_OFF)) |=> $stable(tape_sel))
        else $error("tape select changed without a write");

endmodule : mivl_latch_bank

// ===== design/mivl_pkg.sv
// package: register map, field layout and reset values of the media-id valid latch
package mivl_pkg;

    // ****************************************************************
    // register map
    // ****************************************************************
    localparam int unsigned ADDR_W              = 10;                // host i/o address width
    localparam int unsigned DATA_W              = 8;                 // register data width
    localparam logic [9:0]  TAPE_DRIVE_OFF      = 10'h3F3;           // media_tape_drive_status
    localparam logic [9:0]  FUNC_CTRL_OFF       = 10'h3F6;           // function_control_reg

    // ****************************************************************
    // field positions
    // ****************************************************************
    localparam int unsigned TDR_TAPE_SEL_LSB    = 0;                 // tape select field, bits 1:0
    localparam int unsigned TDR_ID_INVALID_BIT  = 5;                 // media id not valid flag
    localparam int unsigned TDR_MEDIA_ID_LSB    = 6;                 // media id field, bits 7:6
    localparam int unsigned FCR_DATA_RATE_BIT   = 0;                 // data_rate_select

    // ****************************************************************
    // reset values
    // ****************************************************************
    localparam logic [1:0]  TAPE_SEL_RST        = 2'h0;              // no tape drive selected
    localparam logic [7:0]  FCR_RST_UPPER       = 8'h00;             // upper control bits at reset
    localparam logic [7:0]  RDATA_IDLE          = 8'h00;             // read data outside answer cycle
    localparam logic        ID_MEANINGLESS      = 1'b1;              // bit 5 shown in data-rate mode

    // ****************************************************************
    // drive count
    // ****************************************************************
    localparam int unsigned NUM_DRIVES          = 2;                 // drives 0 and 1 carry straps

    // layout of the tape drive register as software sees it
    typedef struct packed {
        logic [1:0] media_id;                                        // bits 7:6
        logic       id_invalid;                                      // bit 5
        logic [2:0] unused;                                          // bits 4:2, read zero
        logic [1:0] tape_sel;                                        // bits 1:0
    } mivl_tdr_t;

    // host register access grouped together
    typedef struct packed {
        logic [9:0] addr;                                            // i/o address
        logic [7:0] wdata;                                           // write data
        logic       wr;                                              // write strobe
        logic       rd;                                              // read strobe
    } mivl_bus_req_t;

endpackage : mivl_pkg

// ===== design/mivl_strap_latch.sv
// module: per-drive strap sampler that captures strap levels during reset and holds them
`timescale 1ns/100ps

module mivl_strap_latch
    import mivl_pkg::*;
#(
    parameter int unsigned N = NUM_DRIVES                            // number of strap pins
) (
    input  wire logic         mclk_i,                                // controller clock
    input  wire logic         srst_i,                                // synchronous reset, high
    input  wire logic [N-1:0] strap_i,                               // raw strap levels
    output logic      [N-1:0] strap_o                                // held strap levels
);

    // ****************************************************************
    // sample storage
    // ****************************************************************
    logic [N-1:0] strap;                                             // held levels
    logic [N-1:0] next_strap;                                        // next held levels

    // one bit per drive; a strap follows its pin only while reset is high
    generate
        for (genvar d = 0; d < N; d++) begin : g_drive
            always_comb begin
                // last level seen during reset survives its release
                next_strap[d] = srst_i ? strap_i[d] : strap[d];
            end
        end
    endgenerate

    // register only; sync reset lets the pin level itself be the sample
    always_ff @(posedge mclk_i) begin
        strap <= next_strap;
    end

    assign strap_o = strap;

endmodule : mivl_strap_latch

// ===== tb/mivl_latch_bank_test.sv
// testbench: media-id valid latch, strap sampling and register reads
`timescale 1ns/100ps

module mivl_latch_bank_test;
    import mivl_pkg::*;
    logic              mclk_i, srst_i, drive_sel_i, wr_i, rd_i;      // clock, reset, strobes
    logic [1:0]        media_id_i, tape_sel_o, fit, straps, held, tsel; // ids, straps, model
    logic [9:0]        addr_i;                                       // register address
    logic [7:0]        wdata_i, rdata_o, function_control_reg, d;                     // data and model copy
    logic              data_rate_select_o;                           // control bit 0
    int                n_mismatch, num_checks, cycles, seed;         // counters and seed
    logic [31:0]       r;                                            // random word

    mivl_strap_board u_board (.mclk_i(mclk_i), .srst_i(srst_i), .fit_i(fit), .strap_o(straps));
    mivl_latch_bank u_dut (.mclk_i(mclk_i), .srst_i(srst_i), .media_valid_strap_drive0_n_i(straps[0]),
        .media_valid_strap_drive1_n_i(straps[1]), .drive_sel_i(drive_sel_i), .media_id_i(media_id_i),
        .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
        .data_rate_select_o(data_rate_select_o), .tape_sel_o(tape_sel_o));

    // ****************************************************************
    // clock and hang guard
    // ****************************************************************
    initial begin
        mclk_i = 1'b0;
        forever #5 mclk_i = ~mclk_i;
    end
    // whole run needs under 2000 cycles, so 5000 means a hang
    always @(posedge mclk_i) begin
        cycles++;
        if (cycles == 5000) begin
            n_mismatch++;
            end_of_test();
        end
    end

    // ****************************************************************
    // helpers
    // ****************************************************************
    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("unexpected %s: expected %h seen %h", name, exp, seen);
        end
    endtask : check

    // bit 5 is forced in data-rate mode, otherwise the held strap of that drive
    function automatic logic [7:0] exp_tdr(input logic [1:0] mid, input logic drv);
        exp_tdr = {mid, function_control_reg[FCR_DATA_RATE_BIT] ? ID_MEANINGLESS : held[drv], 3'h0, tsel};
    endfunction : exp_tdr

    task automatic bus_wr(input logic [9:0] a, input logic [7:0] v);
        @(posedge mclk_i);
        wr_i <= 1'b1; addr_i <= a; wdata_i <= v;
        @(posedge mclk_i);
        wr_i <= 1'b0;
        if (a == FUNC_CTRL_OFF) function_control_reg = v;
        if (a == TAPE_DRIVE_OFF) tsel = v[1:0];
        #1 check("data_rate_select", {7'h0, data_rate_select_o}, {7'h0, function_control_reg[0]});
        check("tape_sel", {6'h0, tape_sel_o}, {6'h0, tsel});
    endtask : bus_wr

    // drive select and media id are flipped after the strobe: they must be taken with it
    task automatic bus_rd(input logic [9:0] a, input logic drv, input logic [1:0] mid, output logic [7:0] v);
        @(posedge mclk_i);
        rd_i <= 1'b1; addr_i <= a; drive_sel_i <= drv; media_id_i <= mid;
        @(posedge mclk_i);
        rd_i <= 1'b0; drive_sel_i <= ~drv; media_id_i <= ~mid;
        #1 v = rdata_o;
        @(posedge mclk_i);
        #1 check("rdata_idle", rdata_o, RDATA_IDLE);
    endtask : bus_rd

    task automatic read_tdr(input logic drv, input logic [1:0] mid);
        bus_rd(TAPE_DRIVE_OFF, drv, mid, d);
        check("tape_drive_status", d, exp_tdr(mid, drv));
    endtask : read_tdr

    task automatic do_reset(input logic [1:0] f);
        @(posedge mclk_i);
        fit <= f; srst_i <= 1'b1;
        repeat (4) @(posedge mclk_i);
        srst_i <= 1'b0;
        held = f; function_control_reg = {7'h0, f[0]}; tsel = TAPE_SEL_RST;
        @(posedge mclk_i);
        #1 check("data_rate_select", {7'h0, data_rate_select_o}, function_control_reg);
    endtask : do_reset

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : end_of_test

    // ****************************************************************
    // main sequence
    // ****************************************************************
    initial begin
        srst_i = 1'b1; wr_i = 1'b0; rd_i = 1'b0; fit = 2'h0; drive_sel_i = 1'b0;
        media_id_i = 2'h0; addr_i = 10'h000; wdata_i = 8'h00; seed = 24246;
        n_mismatch = 0; num_checks = 0; cycles = 0;
        // every strap combination, both modes, both drives
        for (int k = 0; k < 4; k++) begin
            do_reset(k[1:0]);
            repeat (3) @(posedge mclk_i);                            // pins drift meanwhile
            read_tdr(1'b0, 2'h2);
            read_tdr(1'b1, 2'h1);
            bus_wr(FUNC_CTRL_OFF, 8'h00);
            read_tdr(1'b0, 2'h3);
            read_tdr(1'b1, 2'h0);
            bus_wr(FUNC_CTRL_OFF, 8'h01);
            read_tdr(1'b1, 2'h3);
        end
        // random mix of accesses, unmapped places among them
        for (int i = 0; i < 200; i++) begin
            r = $random(seed);
            case (r[2:0])
                3'h0: bus_wr(FUNC_CTRL_OFF, r[15:8]);
                3'h1: bus_wr(TAPE_DRIVE_OFF, r[15:8]);
                3'h2: begin
                    bus_rd(FUNC_CTRL_OFF, r[3], r[5:4], d);
                    check("function_control", d, function_control_reg);
                end
                3'h3: begin
                    if (r[25:16] == TAPE_DRIVE_OFF || r[25:16] == FUNC_CTRL_OFF) r[25:16] = 10'h000;
                    bus_wr(r[25:16], r[15:8]);
                    bus_rd(r[25:16], r[3], r[5:4], d);
                    check("unmapped_read", d, 8'h00);
                end
                default: read_tdr(r[3], r[5:4]);
            endcase
        end
        end_of_test();
    end
endmodule : mivl_latch_bank_test

// ===== tb/mivl_strap_board.sv
// partner model: board strap resistors on both media-valid pins
`timescale 1ns/100ps

module mivl_strap_board (
    input  wire logic       mclk_i,                                  // controller clock
    input  wire logic       srst_i,                                  // reset seen by the board
    input  wire logic [1:0] fit_i,                                   // 1 = pull-up fitted, per drive
    output logic      [1:0] strap_o                                  // pin levels, index = drive
);
    logic [1:0] drift;                                               // pin noise once reset is over

    // ****************************************************************
    // pin levels
    // ****************************************************************
    // outside reset the pins are not held, so a level that changes every
    // cycle shows up any latch that keeps sampling after reset
    always_ff @(posedge mclk_i) begin
        drift <= srst_i ? ~fit_i : ~drift;
    end
    assign strap_o = srst_i ? fit_i : drift;                         // pull-up beats the pull-down
endmodule : mivl_strap_board
